// file: design/nws_pkg.sv
`default_nettype none

package nws_pkg;

  // ==========================================================================
  // Array organisation
  // ==========================================================================
  localparam int unsigned ARRAY_BITS     = 18874368;
  localparam int unsigned LANE_W         = 9;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned WORD_W_WIDE    = 72;
  localparam int unsigned WORD_W_DEFAULT = 36;
  localparam int unsigned WORD_W_NARROW  = 18;

  // ==========================================================================
  // Burst counter and pipeline
  // ==========================================================================
  localparam int unsigned BURST_W           = 2;
  localparam logic [1:0]  BURST_START       = 2'h0;
  localparam logic [1:0]  BURST_STEP        = 2'h1;
  localparam logic        BURST_INTERLEAVED = 1'b1;
  localparam int unsigned PIPE_LATENCY      = 2;
  localparam int unsigned CLOCK_PERIOD_PS   = 4000;
  localparam int unsigned FIFO_DEPTH        = 8;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } nws_op_type;

  localparam nws_op_type OP_RESET = OP_IDLE;

  // Low address bits for one beat of a burst
  function automatic logic [1:0] burst_offset(
    input logic [1:0] seed,
    input logic [1:0] step,
    input logic       interleaved
  );
    burst_offset = interleaved ? (seed ^ step) : (seed + step);
  endfunction

endpackage

`default_nettype wire

// file: design/nws_stream_if.sv
`timescale 1ns/1ps
`default_nettype none

interface nws_stream_if #(
  parameter int unsigned width = 8
);
  logic             valid;
  logic             ready;
  logic [width-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : nws_stream_if

`default_nettype wire

// file: design/nws_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module nws_fifo #(
  parameter int unsigned width = 8,
  parameter int unsigned depth = 8
) (
  input  wire logic   clock,
  input  wire logic   rstn,
  nws_stream_if.sink   push,
  nws_stream_if.source pop
);
  import nws_pkg::*;

  localparam int unsigned PTR_W = $clog2(depth);

  logic [width-1:0] store [depth];
  logic [PTR_W:0]   wr_ptr_r;
  logic [PTR_W:0]   wr_ptr_nxt;
  logic [PTR_W:0]   rd_ptr_r;
  logic [PTR_W:0]   rd_ptr_nxt;
  logic             full;
  logic             empty;
  logic             do_push;
  logic             do_pop;

  // ==========================================================================
  // Flags and pointers
  // ==========================================================================
  always_comb begin
    empty      = (wr_ptr_r == rd_ptr_r);
    full       = (wr_ptr_r[PTR_W] != rd_ptr_r[PTR_W]) &&
                 (wr_ptr_r[PTR_W-1:0] == rd_ptr_r[PTR_W-1:0]);
    push.ready = !full;
    pop.valid  = !empty;
    pop.data   = store[rd_ptr_r[PTR_W-1:0]];
    do_push    = push.valid && !full;
    do_pop     = pop.ready && !empty;
    wr_ptr_nxt = do_push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = do_pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // Storage has no reset; the pointers alone say what is valid
  always_ff @(posedge clock) begin
    if (do_push) begin
      store[wr_ptr_r[PTR_W-1:0]] <= push.data;
    end
  end

endmodule // nws_fifo

`default_nettype wire

// file: design/nws_sram.sv
// Overview of operation
// - All synchronous inputs are captured on the rising clock edge.
// - Clock enable high freezes the pipeline; output enable and sleep still gate the drivers.
// - Advance/load high steps the burst counter for the next address.
// - Advance/load low starts read, write or deselect with a new address.
// - Burst counter is two bits, wrapping after four beats.
// - Two lowest address bits seed the burst counter start value.
// - Write starts at edge with write enable low, then self-times.
// - Only byte lanes with their byte-write enable asserted are written.
// - Mode strap high gives interleaved order, low gives linear order.
// - Reads and writes may follow each other with no idle cycle.
// - Word width 72, 36 or 18 bits, depth 256K, 512K or 1M.
// - Three chip enables, all asserted while sleep is low, select the device.
`timescale 1ns/1ps
`default_nettype none

module nws_sram #(
  parameter  int unsigned word_w  = nws_pkg::WORD_W_DEFAULT,
  localparam int unsigned lanes_p = word_w / nws_pkg::LANE_W,
  localparam int unsigned addr_w  = $clog2(nws_pkg::ARRAY_BITS / word_w)
) (
  input  wire logic [addr_w-1:0]              clock_addr_unused_guard,
  input  wire logic                           clock,
  input  wire logic                           rstn,
  input  wire logic [addr_w-1:0]              addr,
  input  wire logic                           clock_enable_n,
  input  wire logic                           advance_load,
  input  wire logic                           write_enable_n,
  input  wire logic [lanes_p-1:0]             byte_write_n,
  input  wire logic                           chip_select_n,
  input  wire logic                           chip_select_hi,
  input  wire logic                           chip_select2_n,
  input  wire logic                           output_enable_n,
  input  wire logic                           burst_mode,
  input  wire logic                           sleep_request,
  input  wire logic [lanes_p*nws_pkg::BYTE_W-1:0] data_io_i,
  output var  logic [lanes_p*nws_pkg::BYTE_W-1:0] data_io_o,
  output var  logic                           data_io_oe,
  input  wire logic [lanes_p-1:0]             parity_io_i,
  output var  logic [lanes_p-1:0]             parity_io_o,
  output var  logic                           parity_io_oe
);
  import nws_pkg::*;

  localparam int unsigned DEPTH   = 2 ** addr_w;
  localparam int unsigned DATA_W  = lanes_p * BYTE_W;
  localparam int unsigned ENTRY_W = word_w + 1 + addr_w;

  // ==========================================================================
  // Storage and helpers
  // ==========================================================================
  // word and depth from the chosen width
  logic [word_w-1:0] mem [DEPTH];

  function automatic logic [word_w-1:0] merge_lanes(
    input logic [word_w-1:0]  old_w,
    input logic [word_w-1:0]  new_w,
    input logic [lanes_p-1:0] lane_we
  );
    logic [word_w-1:0] res;
    res = old_w;
    for (int k = 0; k < lanes_p; k++) begin
      if (lane_we[k]) begin
        res[k*LANE_W +: LANE_W] = new_w[k*LANE_W +: LANE_W];
      end
    end
    merge_lanes = res;
  endfunction

  // Pin word: each lane keeps its parity bit above its eight data bits
  logic [word_w-1:0] pin_word;

  always_comb begin
    pin_word = '0;
    for (int k = 0; k < lanes_p; k++) begin
      pin_word[k*LANE_W +: LANE_W] = {parity_io_i[k],
                                      data_io_i[k*BYTE_W +: BYTE_W]};
    end
  end

  // ==========================================================================
  // Advance control
  // ==========================================================================
  logic fifo_in_ready;
  logic step;

  // suspend: the pipeline does not step while clock enable is high; the drive enable still follows output enable and sleep
  always_comb begin
    step = !clock_enable_n && fifo_in_ready;
  end

  // ==========================================================================
  // Burst address generator and input registers
  // ==========================================================================
  logic [addr_w-3:0]  base_r;
  logic [addr_w-3:0]  base_nxt;
  logic [1:0]         seed_r;
  logic [1:0]         seed_nxt;
  logic [1:0]         cnt_r;
  logic [1:0]         cnt_nxt;
  nws_op_type         s1_op_r;
  nws_op_type         s1_op_nxt;
  logic [addr_w-1:0]  s1_addr_r;
  logic [addr_w-1:0]  s1_addr_nxt;
  logic [lanes_p-1:0] s1_we_r;
  logic [lanes_p-1:0] s1_we_nxt;
  logic               selected;

  always_comb begin
    // all three enables must be asserted
    selected    = !chip_select_n && chip_select_hi && !chip_select2_n &&
                  !sleep_request;
    base_nxt    = base_r;
    seed_nxt    = seed_r;
    cnt_nxt     = cnt_r;
    s1_op_nxt   = s1_op_r;
    s1_we_nxt   = s1_we_r;
    s1_addr_nxt = s1_addr_r;
    if (step) begin
      if (!advance_load) begin
        base_nxt = addr[addr_w-1:2];
        seed_nxt = addr[1:0];
        cnt_nxt  = BURST_START;
        if (!selected) begin
          s1_op_nxt = OP_IDLE;
        end else if (!write_enable_n) begin
          s1_op_nxt = OP_WRITE;
        end else begin
          s1_op_nxt = OP_READ;
        end
      end else begin
        // two-bit count wraps after four beats
        cnt_nxt = cnt_r + BURST_STEP;
        if (sleep_request) begin
          s1_op_nxt = OP_IDLE;
        end
      end
      // byte enables captured each active edge
      s1_we_nxt   = ~byte_write_n;
      s1_addr_nxt = {base_nxt, burst_offset(seed_nxt, cnt_nxt, burst_mode)};
    end
  end

  // input registers on the rising edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      base_r    <= '0;
      seed_r    <= BURST_START;
      cnt_r     <= BURST_START;
      s1_op_r   <= OP_RESET;
      s1_we_r   <= '0;
      s1_addr_r <= '0;
    end else begin
      base_r    <= base_nxt;
      seed_r    <= seed_nxt;
      cnt_r     <= cnt_nxt;
      s1_op_r   <= s1_op_nxt;
      s1_we_r   <= s1_we_nxt;
      s1_addr_r <= s1_addr_nxt;
    end
  end

  // ==========================================================================
  // Second stage: operation and address delay
  // ==========================================================================
  nws_op_type         s2_op_r;
  nws_op_type         s2_op_nxt;
  logic [addr_w-1:0]  s2_addr_r;
  logic [addr_w-1:0]  s2_addr_nxt;
  logic [lanes_p-1:0] s2_we_r;
  logic [lanes_p-1:0] s2_we_nxt;
  logic               array_write;

  always_comb begin
    s2_op_nxt   = s2_op_r;
    s2_addr_nxt = s2_addr_r;
    s2_we_nxt   = s2_we_r;
    if (step) begin
      s2_op_nxt   = s1_op_r;
      s2_addr_nxt = s1_addr_r;
      s2_we_nxt   = s1_we_r;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s2_op_r   <= OP_RESET;
      s2_addr_r <= '0;
      s2_we_r   <= '0;
    end else begin
      s2_op_r   <= s2_op_nxt;
      s2_addr_r <= s2_addr_nxt;
      s2_we_r   <= s2_we_nxt;
    end
  end

  // ==========================================================================
  // Third stage: write data phase
  // ==========================================================================
  // Write data is taken in the pin slot where read data of the same load
  // would stand, so a read and a write on adjacent loads never both drive.
  nws_op_type         s3_op_r;
  nws_op_type         s3_op_nxt;
  logic [addr_w-1:0]  s3_addr_r;
  logic [addr_w-1:0]  s3_addr_nxt;
  logic [lanes_p-1:0] s3_we_r;
  logic [lanes_p-1:0] s3_we_nxt;

  always_comb begin
    s3_op_nxt   = s3_op_r;
    s3_addr_nxt = s3_addr_r;
    s3_we_nxt   = s3_we_r;
    if (step) begin
      s3_op_nxt   = s2_op_r;
      s3_addr_nxt = s2_addr_r;
      s3_we_nxt   = s2_we_r;
    end
    // write data sampled in the read data slot
    array_write = 1'b0;
    if (step) begin
      unique case (s3_op_r)
        OP_WRITE: array_write = 1'b1;
        OP_READ:  array_write = 1'b0;
        OP_IDLE:  array_write = 1'b0;
        default:  array_write = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s3_op_r   <= OP_RESET;
      s3_addr_r <= '0;
      s3_we_r   <= '0;
    end else begin
      s3_op_r   <= s3_op_nxt;
      s3_addr_r <= s3_addr_nxt;
      s3_we_r   <= s3_we_nxt;
    end
  end

  // self-timed array write, no further master action
  always_ff @(posedge clock) begin
    if (array_write) begin
      mem[s3_addr_r] <= merge_lanes(mem[s3_addr_r], pin_word, s3_we_r);
    end
  end

  // ==========================================================================
  // Array read with bypass into the read buffer
  // ==========================================================================
  nws_stream_if #(.width(ENTRY_W)) rd_push ();
  nws_stream_if #(.width(ENTRY_W)) rd_pop ();

  logic [word_w-1:0] rd_word;

  // a read two loads behind a write to the same word sees the new data
  always_comb begin
    rd_word = mem[s1_addr_r];
    if (array_write && (s3_addr_r == s1_addr_r)) begin
      rd_word = merge_lanes(rd_word, pin_word, s3_we_r);
    end
    rd_push.valid = !clock_enable_n;
    rd_push.data  = {s1_addr_r, (s1_op_r == OP_READ), rd_word};
    fifo_in_ready = rd_push.ready;
    rd_pop.ready  = step;
  end

  // Every active cycle pushes one entry, so the buffer depth adds no latency
  // but lets a stalled drain hold results without losing them.
  nws_fifo #(
    .width (ENTRY_W),
    .depth (FIFO_DEPTH)
  ) u_read_buffer (
    .clock (clock),
    .rstn  (rstn),
    .push  (rd_push),
    .pop   (rd_pop)
  );

  // ==========================================================================
  // Output drivers
  // ==========================================================================
  logic              drive_r;
  logic              drive_nxt;
  logic [DATA_W-1:0] dout_nxt;
  logic [lanes_p-1:0] pout_nxt;
  logic              oe_nxt;
  logic [word_w-1:0] out_word;

  always_comb begin
    drive_nxt = drive_r;
    dout_nxt  = data_io_o;
    pout_nxt  = parity_io_o;
    // a write loaded just before this read lands now; fold it in
    out_word  = rd_pop.data[word_w-1:0];
    if (array_write && (rd_pop.data[ENTRY_W-1 -: addr_w] == s3_addr_r)) begin
      out_word = merge_lanes(out_word, pin_word, s3_we_r);
    end
    // read word leaves two edges after its address
    if (step) begin
      drive_nxt = rd_pop.valid && rd_pop.data[word_w];
      if (rd_pop.valid) begin
        for (int k = 0; k < lanes_p; k++) begin
          dout_nxt[k*BYTE_W +: BYTE_W] = out_word[k*LANE_W +: BYTE_W];
          pout_nxt[k] = out_word[k*LANE_W + BYTE_W];
        end
      end
    end
    // output enable gates drivers; never on for write or idle
    oe_nxt = drive_nxt && !output_enable_n && !sleep_request;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      drive_r      <= 1'b0;
      data_io_o    <= '0;
      parity_io_o  <= '0;
      data_io_oe   <= 1'b0;
      parity_io_oe <= 1'b0;
    end else begin
      drive_r      <= drive_nxt;
      data_io_o    <= dout_nxt;
      parity_io_o  <= pout_nxt;
      data_io_oe   <= oe_nxt;
      parity_io_oe <= oe_nxt;
    end
  end

endmodule // nws_sram

`default_nettype wire

// file: tb/nws_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Controller side of the shared data and parity pins
// ======
module nws_ctl_model (
  input  wire logic        clock,
  input  wire logic        drive,
  input  wire logic [35:0] wdata,
  input  wire logic [35:0] sram_q,
  input  wire logic        sram_oe,
  output var  logic [35:0] pins,
  output var  logic        clash
);
  logic [35:0] last_r = 36'h0;
  // released pins float
  // Floating pins show the inverse of the last level, never a held copy
  always_comb begin
    pins = ~last_r;
    if (drive) pins = wdata;
    if (sram_oe) pins = sram_q;
  end
  always_ff @(posedge clock) last_r <= pins;
  assign clash = drive && sram_oe;
endmodule // nws_ctl_model
`default_nettype wire

// file: tb/nws_sram_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Pin-level checks
// ======
module nws_sram_chk #(
  parameter  int unsigned word_w  = nws_pkg::WORD_W_DEFAULT,
  localparam int unsigned lanes_p = word_w / nws_pkg::LANE_W
) (
  input wire logic                 clock,
  input wire logic                 rstn,
  input wire logic                 clock_enable_n,
  input wire logic                 advance_load,
  input wire logic                 write_enable_n,
  input wire logic                 chip_select_n,
  input wire logic                 chip_select_hi,
  input wire logic                 chip_select2_n,
  input wire logic                 output_enable_n,
  input wire logic                 sleep_request,
  input wire logic [lanes_p*8-1:0] data_io_o,
  input wire logic                 data_io_oe,
  input wire logic                 parity_io_oe
);
  wire logic act = !clock_enable_n;
  wire logic ld  = act && !advance_load;
  wire logic sel = !chip_select_n && chip_select_hi && !chip_select2_n
                   && !sleep_request;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_rd;
    ld && sel && write_enable_n ##1 act
      ##1 (act && !output_enable_n && !sleep_request);
  endsequence
  sequence s_wr;
    ld && sel && !write_enable_n ##1 act ##1 act;
  endsequence
  sequence s_des;
    ld && !sel ##1 act ##1 act;
  endsequence
  a_read_drives: assert property (
    s_rd |=> data_io_oe) else $error("read slot not driven");
  a_write_quiet: assert property (
    s_wr |=> !data_io_oe) else $error("pins driven in write slot");
  a_desel_quiet: assert property (
    s_des |=> !data_io_oe) else $error("deselected slot driven");
  a_turn_around: assert property (
    (ld && sel && !write_enable_n) ##1 s_rd |=> data_io_oe)
    else $error("read after write not driven");
  a_oen_gates: assert property (
    output_enable_n |=> !data_io_oe) else $error("drive with oe off");
  a_sleep_quiet: assert property (
    sleep_request |=> !data_io_oe) else $error("drive during sleep");
  a_lanes_pair: assert property (
    data_io_oe == parity_io_oe) else $error("data and parity oe differ");
  a_suspend_hold: assert property (
    clock_enable_n |=> $stable(data_io_o))
    else $error("read data moved while suspended");
  a_reset_clear: assert property (disable iff (1'b0)
    !rstn |-> !data_io_oe && data_io_o == '0)
    else $error("outputs not cleared in reset");
endmodule // nws_sram_chk

bind nws_sram nws_sram_chk #(.word_w(word_w)) i_nws_sram_chk (
  .clock(clock), .rstn(rstn), .clock_enable_n(clock_enable_n),
  .advance_load(advance_load), .write_enable_n(write_enable_n),
  .chip_select_n(chip_select_n), .chip_select_hi(chip_select_hi),
  .chip_select2_n(chip_select2_n), .output_enable_n(output_enable_n),
  .sleep_request(sleep_request), .data_io_o(data_io_o),
  .data_io_oe(data_io_oe), .parity_io_oe(parity_io_oe));
`default_nettype wire

// file: tb/nws_sram_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nws_sram_tb;
  import nws_pkg::*;
  typedef struct packed {
    logic ld; logic wr; logic [1:0] cs; logic md; logic st;
    logic [18:0] a; logic [3:0] bw; logic [35:0] d;
  } nws_row_type;
  // ======
  // Rows: load, write, chip select case, mode, stall, address, lanes, data
  // ======
  localparam nws_row_type ROWS [0:20] = '{
    '{1,1,0,0,0,19'h20,4'h0,36'h9_5A5A_5A5A},
    '{1,1,0,0,0,19'h10,4'h0,36'h9_A5A5_A5A5},
    '{1,0,0,0,0,19'h10,4'h0,36'h0},
    '{1,1,0,0,0,19'h10,4'hA,36'h0_0F0F_0F0F},
    '{1,0,0,0,0,19'h10,4'h0,36'h0},
    '{1,1,1,0,0,19'h20,4'h0,36'h0},
    '{1,1,2,0,0,19'h20,4'h0,36'h0},
    '{1,1,3,0,1,19'h20,4'h0,36'h0},
    '{1,0,0,0,0,19'h20,4'h0,36'h0},
    '{1,1,0,0,0,19'h101,4'h0,36'h1_1111_1111},
    '{0,0,0,0,1,19'h102,4'h0,36'h2_2222_2222},
    '{0,0,0,0,0,19'h103,4'h5,36'h3_3333_3333},
    '{0,0,0,0,0,19'h100,4'h0,36'h4_4444_4444},
    '{1,0,0,1,0,19'h101,4'h0,36'h0},
    '{0,0,0,1,0,19'h100,4'h0,36'h0},
    '{0,0,0,1,1,19'h103,4'h0,36'h0},
    '{0,0,0,1,0,19'h102,4'h0,36'h0},
    '{1,0,1,0,0,19'h0,4'h0,36'h0},
    '{0,0,0,0,0,19'h1,4'h0,36'h0},
    '{1,0,1,0,0,19'h0,4'h0,36'h0},
    '{1,0,1,0,0,19'h0,4'h0,36'h0}};
  logic clock = 1'b0, rstn = 1'b1, clock_enable_n = 1'b1;
  logic advance_load = 1'b0, write_enable_n = 1'b1, chip_select_n = 1'b1;
  logic chip_select_hi = 1'b0, chip_select2_n = 1'b1, burst_mode = 1'b0;
  logic output_enable_n = 1'b1, sleep_request = 1'b0, drive = 1'b0;
  logic [18:0] addr = 19'h0;
  logic [3:0]  byte_write_n = 4'hF;
  logic [35:0] wdata = 36'h0, pins, sram_q, m;
  logic [31:0] data_io_o;
  logic [3:0]  parity_io_o;
  logic        data_io_oe, parity_io_oe, clash, quiet = 1'b0, slp = 1'b0;
  logic [35:0] ref_m [int];
  logic [1:0]  ty = 2'h0;
  logic        pv [3] = '{1'b0, 1'b0, 1'b0};
  logic        ev [3] = '{1'b0, 1'b0, 1'b0};
  logic [18:0] pa [3], ea [3];
  logic [3:0]  pb [3];
  logic [35:0] pd [3];
  int n_fail = 0, n_compared = 0, cyc = 0;
  assign sram_q = {parity_io_o, data_io_o};
  initial forever #2 clock = ~clock;
  nws_sram i_nws_sram (.clock_addr_unused_guard('0), .clock(clock),
    .rstn(rstn), .addr(addr), .clock_enable_n(clock_enable_n),
    .advance_load(advance_load), .write_enable_n(write_enable_n),
    .byte_write_n(byte_write_n), .chip_select_n(chip_select_n),
    .chip_select_hi(chip_select_hi), .chip_select2_n(chip_select2_n),
    .output_enable_n(output_enable_n), .burst_mode(burst_mode),
    .sleep_request(sleep_request), .data_io_i(pins[31:0]),
    .data_io_o(data_io_o), .data_io_oe(data_io_oe),
    .parity_io_i(pins[35:32]), .parity_io_o(parity_io_o),
    .parity_io_oe(parity_io_oe));
  nws_ctl_model i_nws_ctl_model (.clock(clock), .drive(drive),
    .wdata(wdata), .sram_q(sram_q), .sram_oe(data_io_oe), .pins(pins),
    .clash(clash));
  task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_data({35'h0, got}, {35'h0, exp});
  endtask
  task automatic print_verdict();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic beat(input nws_row_type r);
    if (r.st) begin
      @(posedge clock);
      clock_enable_n <= 1'b1;
    end
    @(posedge clock);
    if (r.ld) ty = (r.cs != 2'h0 || slp) ? 2'h0 : (r.wr ? 2'h2 : 2'h1);
    advance_load    <= !r.ld;
    clock_enable_n  <= 1'b0;
    write_enable_n  <= !r.wr;
    chip_select_n   <= (r.cs == 2'h1);
    chip_select_hi  <= (r.cs != 2'h2);
    chip_select2_n  <= (r.cs == 2'h3);
    // seed from low bits; advance beats carry a wrong address
    addr            <= r.ld ? r.a : ~r.a;
    byte_write_n    <= r.bw;
    burst_mode      <= r.md;
    output_enable_n <= quiet;
    sleep_request   <= slp;
    drive           <= pv[2];
    wdata           <= pd[2];
    #1;
    chk_bit(data_io_oe, ev[2] && !quiet);
    if (ev[2] && !quiet) chk_data(sram_q, ref_m[ea[2]]);
    chk_bit(clash, 1'b0);
    if (pv[2]) begin
      m = ref_m.exists(pa[2]) ? ref_m[pa[2]] : 36'h0;
      for (int k = 0; k < 4; k++) begin
        if (!pb[2][k]) m[8*k+:8] = pd[2][8*k+:8];
        if (!pb[2][k]) m[32+k] = pd[2][32+k];
      end
      ref_m[pa[2]] = m;
    end
    pv[2] = pv[1]; pa[2] = pa[1]; pb[2] = pb[1]; pd[2] = pd[1];
    pv[1] = pv[0]; pa[1] = pa[0]; pb[1] = pb[0]; pd[1] = pd[0];
    pv[0] = (ty == 2'h2); pa[0] = r.a; pb[0] = r.bw; pd[0] = r.d;
    ev[2] = ev[1]; ev[1] = ev[0]; ev[0] = (ty == 2'h1);
    ea[2] = ea[1]; ea[1] = ea[0]; ea[0] = r.a;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    rstn <= 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    // bursts, lanes, order and suspend in the rows
    foreach (ROWS[i]) beat(ROWS[i]);
    $display("table rows done");
    for (int s = 0; s < 2; s++) begin
      quiet = (s == 0);
      slp = (s == 1);
      beat(ROWS[4]);
      repeat (3) beat(ROWS[19]);
    end
    quiet = 1'b0;
    slp = 1'b0;
    beat(ROWS[19]);
    $display("output enable and sleep done");
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk_bit(data_io_oe, 1'b0);
    chk_data(sram_q, 36'h0);
    @(posedge clock);
    rstn <= 1'b1;
    beat(ROWS[1]);
    beat(ROWS[2]);
    repeat (3) beat(ROWS[19]);
    $display("mid-run reset done");
    print_verdict();
  end
endmodule // nws_sram_tb
`default_nettype wire
